// ---- hdl/pimpc_consts.svh ----
// Offsets, field positions, reset values and counts of the port ingress MAC control block
`ifndef PIMPC_CONSTS_SVH
`define PIMPC_CONSTS_SVH

`define PIMPC_PAGE_MAC_A        12'h400
`define PIMPC_PAGE_MAC_B        12'h401
`define PIMPC_PAGE_RATE         12'h403
`define PIMPC_PAGE_XPORT_B      12'h301
`define PIMPC_XPORT_NUM         4'h5
`define PIMPC_RST_REG           8'h00
`define PIMPC_MASK_MAC_A        8'h0B
`define PIMPC_MASK_MAC_B        8'hBF
`define PIMPC_MASK_RATE         8'h7F
`define PIMPC_MASK_XPORT_B      8'h07

`define PIMPC_BIT_STORM         1
`define PIMPC_BIT_JUMBO         0
`define PIMPC_BIT_BACKPRESS     3
`define PIMPC_BIT_PASS_ALL      0
`define PIMPC_BIT_PORT_BASED    6
`define PIMPC_BIT_PKT_RATE      5
`define PIMPC_BIT_RATE_FC       4
`define PIMPC_BIT_MODE_HI       3
`define PIMPC_BIT_MODE_LO       2
`define PIMPC_BIT_IFG           1
`define PIMPC_BIT_PREAMBLE      0
`define PIMPC_BIT_XMODE         2
`define PIMPC_BIT_XTYPE_HI      1
`define PIMPC_BIT_XTYPE_LO      0

`define PIMPC_JUMBO_PAYLOAD     14'h2328
`define PIMPC_STD_PAYLOAD       14'h05DC
`define PIMPC_HDR_CRC_BYTES     14'h0012
`define PIMPC_MIN_FRAME         14'h0040
`define PIMPC_IFG_BYTES         14'h000C
`define PIMPC_PREAMBLE_BYTES    14'h0008
`define PIMPC_PKT_CHARGE        14'h0001
`define PIMPC_STRAP_SETTLE      2'h3

`endif

// ---- hdl/pimpc_pkg.sv ----
// Types shared by the port ingress MAC control block
package pimpc_pkg;

    typedef enum logic [1:0] {
        pimpc_lim_all,
        pimpc_lim_flood,
        pimpc_lim_bmcast,
        pimpc_lim_bcast
    } pimpc_lim_mode_type;

    typedef struct packed {
        logic               storm_en;
        logic               jumbo_en;
        logic               backpress_en;
        logic               pass_all;
        logic               port_based;
        logic               packet_rate_mode;
        logic               rate_fc_en;
        pimpc_lim_mode_type lim_mode;
        logic               interframe_gap;
        logic               preamble;
    } pimpc_cfg_type;

    typedef struct packed {
        logic [2:0]  port;
        logic [13:0] length;
        logic        bcast;
        logic        mcast;
        logic        flood_ucast;
        logic        crc_err;
        logic        flow_ctrl;
        logic [2:0]  prio;
    } pimpc_frame_type;

    typedef struct packed {
        logic [2:0]  port;
        logic        forward;
        logic        mirror_only;
        logic        counted;
        logic        prio_based;
        logic [2:0]  prio;
        logic [13:0] charge;
    } pimpc_dec_type;

endpackage

// ---- hdl/pimpc_port_regs.sv ----
// One port's MAC control and ingress rate control register set
`timescale 1ns/1ps
`include "pimpc_consts.svh"
module pimpc_port_regs (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       wr_a,
    input  wire logic       wr_b,
    input  wire logic       wr_rate,
    input  wire logic [7:0] wdata,
    output logic      [7:0] mac_a,
    output logic      [7:0] mac_b,
    output logic      [7:0] rate
);
    // Read-only bits are held at zero by masking every write
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mac_a <= `PIMPC_RST_REG;
            mac_b <= `PIMPC_RST_REG;
            rate  <= `PIMPC_RST_REG;
        end else begin
            if (wr_a) begin
                mac_a <= wdata & `PIMPC_MASK_MAC_A;
            end
            if (wr_b) begin
                mac_b <= wdata & `PIMPC_MASK_MAC_B;
            end
            if (wr_rate) begin
                rate <= wdata & `PIMPC_MASK_RATE;
            end
        end
    end
endmodule

// ---- hdl/pimpc_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pimpc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage <= '0;
            level <= '0;
        end else begin
            stage <= pin;
            level <= stage;
        end
    end
endmodule

// ---- hdl/pimpc_top.sv ----
// Per-port ingress MAC policing control: registers, frame judgement, flow control requests
//
// Notes on behaviour
// - Storm enable drops broadcasts over storm limit
// - Jumbo bit: payload limit 9000, else 1500
// - Back pressure only when enabled and half duplex
// - Full duplex uses separately enabled pause instead
// - Bad frames dropped; pass-all forwards for mirroring
// - Pass-all never affects flow control frame filtering
// - Bit 6: port-wide limit, else per priority
// - Bit 5: count packets, else count bytes
// - Bit 4: rate overrun raises flow control
// - Overrun flow control needs port flow control allowed
// - Mode selects counted frame classes
// - Bit 1 adds 12 gap bytes
// - Bit 0 adds 8 preamble bytes
// - Preamble option ignored in packet mode
// - External port mode and type from straps
// - Type 00 RGMII, 01 RMII, 1x MII
// - Mode bit: MAC/PHY or reference clock direction
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "pimpc_consts.svh"
module pimpc_top (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic [15:0]            reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    input  wire logic                   rx_data_bit1_strap,
    input  wire logic [1:0]             rx_data_bits32_strap,
    input  wire logic [4:0]             port_full_duplex,
    input  wire logic [4:0]             port_congested,
    input  wire logic [4:0]             port_pause_en,
    input  wire logic [4:0]             port_fc_allowed,
    input  wire logic [4:0]             rate_exceeded,
    input  wire logic [4:0]             storm_exceeded,
    input  wire logic                   fc_frame_filter_en,
    input  wire logic                   frm_start,
    input  wire logic [2:0]             frm_start_port,
    input  wire logic                   frm_end,
    input  wire pimpc_pkg::pimpc_frame_type frm,
    output logic                        dec_valid,
    output pimpc_pkg::pimpc_dec_type    dec,
    output logic [4:0]                  backpressure_req,
    output logic [4:0]                  pause_req,
    output logic                        external_mac_port_mode,
    output logic [1:0]                  external_mac_port_type
);
    localparam int NPORT = 5;

    logic [7:0]              mac_a [NPORT];
    logic [7:0]              mac_b [NPORT];
    logic [7:0]              rate  [NPORT];
    pimpc_pkg::pimpc_cfg_type cfg  [NPORT];
    logic [NPORT-1:0]        sel_port;
    logic                    hit_a;
    logic                    hit_b;
    logic                    hit_rate;
    logic                    hit_xport;
    logic [2:0]              addr_slot;
    logic                    addr_slot_ok;
    logic [7:0]              next_rdata;
    logic                    bit1_sync;
    logic [1:0]              bits32_sync;
    logic [1:0]              strap_cnt;
    logic                    strap_done;
    logic [2:0]              xport_b;
    pimpc_pkg::pimpc_cfg_type snap_cfg;
    logic                    snap_ok;
    logic [2:0]              snap_port;
    pimpc_pkg::pimpc_cfg_type use_cfg;
    logic [2:0]              frm_slot;
    logic                    frm_slot_ok;
    logic [2:0]              st_slot;
    logic                    st_slot_ok;
    logic [13:0]             payload;
    logic [13:0]             pay_limit;
    logic                    bad;
    logic                    storm_hit;
    logic                    class_hit;
    logic                    next_forward;
    logic                    next_mirror;
    logic [13:0]             next_charge;

    // Map a switch port number onto its register slot; ports 0, 5 and 6 have none
    function automatic logic [3:0] pimpc_slot(input logic [3:0] num);
        logic [3:0] r;
        r = 4'h8;
        unique case (num)
            4'h1: r = 4'h0;
            4'h2: r = 4'h1;
            4'h3: r = 4'h2;
            4'h4: r = 4'h3;
            4'h7: r = 4'h4;
            default: r = 4'h8;
        endcase
        return r;
    endfunction

    // Register address decode, upper nibble is the port number
    always_comb begin
        logic [3:0] s;
        s            = pimpc_slot(reg_addr[15:12]);
        addr_slot    = s[2:0];
        addr_slot_ok = !s[3];
        hit_a        = addr_slot_ok && reg_addr[11:0] == `PIMPC_PAGE_MAC_A;
        hit_b        = addr_slot_ok && reg_addr[11:0] == `PIMPC_PAGE_MAC_B;
        hit_rate     = addr_slot_ok && reg_addr[11:0] == `PIMPC_PAGE_RATE;
        hit_xport    = reg_addr[15:12] == `PIMPC_XPORT_NUM
                       && reg_addr[11:0] == `PIMPC_PAGE_XPORT_B;
        for (int i = 0; i < NPORT; i++) begin
            sel_port[i] = addr_slot == 3'(i);
        end
    end

    generate
        for (genvar g = 0; g < NPORT; g++) begin : g_port
            pimpc_port_regs u_regs (
                .clk_sys (clk_sys),
                .rst_n   (rst_n),
                .wr_a    (reg_wr && hit_a && sel_port[g]),
                .wr_b    (reg_wr && hit_b && sel_port[g]),
                .wr_rate (reg_wr && hit_rate && sel_port[g]),
                .wdata   (reg_wdata),
                .mac_a   (mac_a[g]),
                .mac_b   (mac_b[g]),
                .rate    (rate[g])
            );
            always_comb begin
                cfg[g].storm_en         = mac_a[g][`PIMPC_BIT_STORM];
                cfg[g].jumbo_en         = mac_a[g][`PIMPC_BIT_JUMBO];
                cfg[g].backpress_en     = mac_b[g][`PIMPC_BIT_BACKPRESS];
                cfg[g].pass_all         = mac_b[g][`PIMPC_BIT_PASS_ALL];
                cfg[g].port_based       = rate[g][`PIMPC_BIT_PORT_BASED];
                cfg[g].packet_rate_mode = rate[g][`PIMPC_BIT_PKT_RATE];
                cfg[g].rate_fc_en       = rate[g][`PIMPC_BIT_RATE_FC];
                cfg[g].lim_mode         = pimpc_pkg::pimpc_lim_mode_type'(
                    rate[g][`PIMPC_BIT_MODE_HI:`PIMPC_BIT_MODE_LO]);
                cfg[g].interframe_gap   = rate[g][`PIMPC_BIT_IFG];
                cfg[g].preamble         = rate[g][`PIMPC_BIT_PREAMBLE];
            end
        end
    endgenerate

    // Read data appear in the cycle after the strobe; unmapped reads give zero
    always_comb begin
        next_rdata = 8'h00;
        if (hit_a) begin
            next_rdata = mac_a[addr_slot];
        end else if (hit_b) begin
            next_rdata = mac_b[addr_slot];
        end else if (hit_rate) begin
            next_rdata = rate[addr_slot];
        end else if (hit_xport) begin
            next_rdata = {5'h00, xport_b};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
        end
    end

    // Straps are pins, so they pass the synchroniser before they are caught
    pimpc_sync #(.WIDTH(3)) u_strap_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pin     ({rx_data_bit1_strap, rx_data_bits32_strap}),
        .level   ({bit1_sync, bits32_sync})
    );

    // Wait for the synchroniser to fill before the strap value is taken
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt  <= 2'h0;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            strap_cnt  <= strap_cnt + 2'h1;
            strap_done <= strap_cnt == `PIMPC_STRAP_SETTLE;
        end
    end

    // External port mode and interface type; software may override after the strap load
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            xport_b <= 3'h0;
        end else if (!strap_done && strap_cnt == `PIMPC_STRAP_SETTLE) begin
            xport_b <= {bit1_sync, bits32_sync};
        end else if (reg_wr && hit_xport) begin
            xport_b <= reg_wdata[2:0];
        end
    end

    // Type 1x means MII; mode bit picks MAC or PHY role, or RMII clock source
    always_comb begin
        external_mac_port_mode = xport_b[`PIMPC_BIT_XMODE];
        external_mac_port_type = xport_b[`PIMPC_BIT_XTYPE_HI:`PIMPC_BIT_XTYPE_LO];
    end

    // Flow control requests, per port, from live settings
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            backpressure_req <= 5'h00;
            pause_req        <= 5'h00;
        end else begin
            for (int i = 0; i < NPORT; i++) begin
                logic rate_fc;
                rate_fc = cfg[i].rate_fc_en && rate_exceeded[i] && port_fc_allowed[i];
                backpressure_req[i] <= !port_full_duplex[i] && cfg[i].backpress_en
                                       && (port_congested[i] || rate_fc);
                pause_req[i] <= port_full_duplex[i]
                                && ((port_pause_en[i] && port_congested[i]) || rate_fc);
            end
        end
    end

    // Settings are frozen at frame start so a write mid-frame cannot split a judgement
    always_comb begin
        logic [3:0] s;
        logic [3:0] t;
        s           = pimpc_slot({1'b0, frm_start_port});
        t           = pimpc_slot({1'b0, frm.port});
        st_slot     = s[2:0];
        st_slot_ok  = !s[3];
        frm_slot    = t[2:0];
        frm_slot_ok = !t[3];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            snap_cfg  <= '0;
            snap_ok   <= 1'b0;
            snap_port <= 3'h0;
        end else if (frm_start && st_slot_ok) begin
            snap_cfg  <= cfg[st_slot];
            snap_ok   <= 1'b1;
            snap_port <= frm_start_port;
        end else if (frm_end) begin
            snap_ok <= 1'b0;
        end
    end

    // Without a matching start the live settings stand in
    always_comb begin
        if (snap_ok && snap_port == frm.port) begin
            use_cfg = snap_cfg;
        end else if (frm_slot_ok) begin
            use_cfg = cfg[frm_slot];
        end else begin
            use_cfg = '0;
        end
    end

    // Frame judgement at frame end
    always_comb begin
        payload   = frm.length - `PIMPC_HDR_CRC_BYTES;
        pay_limit = use_cfg.jumbo_en ? `PIMPC_JUMBO_PAYLOAD : `PIMPC_STD_PAYLOAD;
        bad       = frm.crc_err || frm.length < `PIMPC_MIN_FRAME
                    || (frm.length >= `PIMPC_HDR_CRC_BYTES && payload > pay_limit);
        storm_hit = use_cfg.storm_en && frm.bcast && storm_exceeded[frm_slot];
        unique case (use_cfg.lim_mode)
            pimpc_pkg::pimpc_lim_all:    class_hit = 1'b1;
            pimpc_pkg::pimpc_lim_flood:  class_hit = frm.bcast || frm.mcast || frm.flood_ucast;
            pimpc_pkg::pimpc_lim_bmcast: class_hit = frm.bcast || frm.mcast;
            pimpc_pkg::pimpc_lim_bcast:  class_hit = frm.bcast;
        endcase
        next_forward = 1'b0;
        next_mirror  = 1'b0;
        if (!frm_slot_ok) begin
            next_forward = 1'b0;
        end else if (frm.flow_ctrl && fc_frame_filter_en) begin
            next_forward = 1'b0;
        end else if (bad) begin
            next_forward = use_cfg.pass_all;
            next_mirror  = use_cfg.pass_all;
        end else begin
            next_forward = !storm_hit;
        end
        if (use_cfg.packet_rate_mode) begin
            next_charge = `PIMPC_PKT_CHARGE;
        end else begin
            next_charge = frm.length
                + (use_cfg.interframe_gap ? `PIMPC_IFG_BYTES : 14'h0000)
                + (use_cfg.preamble ? `PIMPC_PREAMBLE_BYTES : 14'h0000);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dec_valid <= 1'b0;
            dec       <= '0;
        end else begin
            dec_valid <= frm_end;
            if (frm_end) begin
                dec.port        <= frm.port;
                dec.forward     <= next_forward;
                dec.mirror_only <= next_mirror;
                dec.counted     <= frm_slot_ok && class_hit;
                dec.prio_based  <= !use_cfg.port_based;
                dec.prio        <= frm.prio;
                dec.charge      <= next_charge;
            end
        end
    end
endmodule

// ---- tb/pimpc_props.sv ----
// Assertions on judgement, read data and flow control at the block ports
`timescale 1ns/1ps
module pimpc_props (
    input logic                       clk_sys,
    input logic                       rst_n,
    input logic                       reg_rd,
    input logic [7:0]                 reg_rdata,
    input logic [4:0]                 port_full_duplex,
    input logic [4:0]                 port_congested,
    input logic [4:0]                 port_pause_en,
    input logic [4:0]                 port_fc_allowed,
    input logic [4:0]                 rate_exceeded,
    input logic                       fc_frame_filter_en,
    input logic                       frm_end,
    input pimpc_pkg::pimpc_frame_type frm,
    input logic                       dec_valid,
    input pimpc_pkg::pimpc_dec_type   dec,
    input logic [4:0]                 backpressure_req,
    input logic [4:0]                 pause_req
);
    // Past-based checks wait until outputs have left reset
    logic [1:0] live;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) live <= 2'h0;
        else if (live != 2'h3) live <= live + 2'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    chk_dec_pulse: assert property (frm_end |=> dec_valid)
        else $error("judgement missing after frame end");
    chk_dec_single: assert property (!frm_end |=> !dec_valid)
        else $error("judgement without frame end");
    chk_dec_hold: assert property (!dec_valid && live[1] |-> $stable(dec))
        else $error("judgement changed between frames");
    chk_dec_port: assert property (dec_valid |-> dec.port == $past(frm.port)
        && dec.prio == $past(frm.prio))
        else $error("judged port or priority differs from frame");
    chk_bad_port: assert property (frm_end && !(frm.port inside {1, 2, 3, 4, 7})
        |=> !dec.forward && !dec.counted)
        else $error("frame of unmapped port passed");
    chk_fc_filter: assert property (frm_end && frm.flow_ctrl && fc_frame_filter_en
        |=> !dec.forward)
        else $error("filtered flow control frame forwarded");
    chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    chk_bp_half: assert property (live[1] |->
        (backpressure_req & $past(port_full_duplex)) == 5'h00)
        else $error("back pressure in full duplex");
    chk_pause_full: assert property (live[1] |->
        (pause_req & ~$past(port_full_duplex)) == 5'h00)
        else $error("pause in half duplex");
    chk_pause_cause: assert property (live[1] |-> (pause_req & ~$past((port_pause_en &
        port_congested) | (rate_exceeded & port_fc_allowed))) == 5'h00)
        else $error("pause without cause");
    chk_pause_cong: assert property (live[1] |->
        ($past(port_full_duplex & port_pause_en & port_congested) & ~pause_req) == 5'h00)
        else $error("pause missing on congestion");
    cov_bad: cover property (frm_end && frm.crc_err);
    cov_mirror: cover property (dec_valid && dec.mirror_only);
    cov_pause: cover property (|pause_req);
    cov_bp: cover property (|backpressure_req);
endmodule
bind pimpc_top pimpc_props u_props (.*);

// ---- tb/pimpc_station.sv ----
// Remote station model delivering frame start and end events into the port
`timescale 1ns/1ps
module pimpc_station (
    input  wire logic                 clk_sys,
    output logic                      frm_start,
    output logic [2:0]                frm_start_port,
    output logic                      frm_end,
    output pimpc_pkg::pimpc_frame_type frm
);
    initial begin
        frm_start = 1'b0;
        frm_start_port = 3'h0;
        frm_end = 1'b0;
        frm = '0;
    end
    // One frame in flight; the caller may pause between begin and end
    task automatic frame_begin(input logic [2:0] p);
        @(posedge clk_sys);
        frm_start <= 1'b1;
        frm_start_port <= p;
        @(posedge clk_sys);
        frm_start <= 1'b0;
        frm_start_port <= ~p;
    endtask
    task automatic frame_end(input logic [2:0] p, input logic [13:0] n, input logic [4:0] f,
                             input logic [2:0] q);
        @(posedge clk_sys);
        frm_end <= 1'b1;
        frm <= {p, n, f, q};
        @(posedge clk_sys);
        frm_end <= 1'b0;
        // Released fields turn inverted so a stale sample cannot match
        frm <= ~{p, n, f, q};
    endtask
endmodule

// ---- tb/port_ingress_mac_policing_ctrl_tb_top.sv ----
// Self-checking bench of the port ingress MAC policing control block
`timescale 1ns/1ps
module port_ingress_mac_policing_ctrl_tb_top;
    localparam logic [18:0] MF = 19'h70000;
    localparam logic [18:0] MC = 19'h08000;
    localparam logic [18:0] MG = 19'h07FFF;
    logic       clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, filt = 1'b1;
    logic       s1 = 1'b1, frm_start, frm_end, dec_valid, x_mode;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [1:0] s32 = 2'h1, x_type;
    logic [4:0] fdx = 5'h00, cong = 5'h00, pen = 5'h00, fca = 5'h00, rexc = 5'h00;
    logic [4:0] sexc = 5'h00, bp, pause;
    logic [2:0] frm_start_port;
    pimpc_pkg::pimpc_frame_type frm;
    pimpc_pkg::pimpc_dec_type   dec;
    int         fail_count = 0, n_compared = 0;
    always #12.5 clk_sys = ~clk_sys;
    pimpc_station st (.*);
    pimpc_top dut (.*, .rx_data_bit1_strap(s1), .rx_data_bits32_strap(s32),
        .port_full_duplex(fdx), .port_congested(cong), .port_pause_en(pen), .port_fc_allowed(fca),
        .rate_exceeded(rexc), .storm_exceeded(sexc), .fc_frame_filter_en(filt),
        .backpressure_req(bp), .pause_req(pause), .external_mac_port_mode(x_mode),
        .external_mac_port_type(x_type));
    task automatic give_verdict;
        if (fail_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic fail(input string m);
        fail_count++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) fail($sformatf("register got %h exp %h", g, e));
    endtask
    task automatic chk_dec(input logic [18:0] e, input logic [18:0] m);
        logic [18:0] g;
        g = {dec_valid, dec.forward, dec.mirror_only, dec.counted, dec.prio_based, dec.charge};
        n_compared++;
        if ((g & m) !== (e & m)) fail($sformatf("judgement got %h exp %h", g & m, e & m));
    endtask
    task automatic chk_fc(input logic [9:0] e);
        n_compared++;
        if ({bp, pause} !== e) fail($sformatf("flow control got %h exp %h", {bp, pause}, e));
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rdr(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk_reg(reg_rdata, e);
    endtask
    task automatic fr(input logic [2:0] p, input logic [13:0] n, input logic [4:0] f,
                      input logic [4:0] e, input logic [13:0] c, input logic [18:0] m);
        st.frame_begin(p);
        st.frame_end(p, n, f, 3'h5);
        #1;
        chk_dec({e, c}, m);
    endtask
    // Slot 0 only: v is {duplex, congested, pause enable, fc allowed, rate exceeded}
    task automatic fc(input logic [4:0] v, input logic [9:0] e);
        @(posedge clk_sys);
        fdx <= {4'h0, v[4]};
        cong <= {4'h0, v[3]};
        pen <= {4'h0, v[2]};
        fca <= {4'h0, v[1]};
        rexc <= {4'h0, v[0]};
        repeat (2) @(posedge clk_sys);
        #1;
        chk_fc(e);
    endtask
    task automatic t_strap;
        chk_reg({5'h00, x_mode, x_type}, 8'h05);
        rdr(16'h5301, 8'h05);
        wr(16'h5301, 8'hFA);
        rdr(16'h5301, 8'h02);
        chk_reg({5'h00, x_mode, x_type}, 8'h02);
    endtask
    task automatic t_regs;
        logic [11:0] pg [3] = '{12'h400, 12'h401, 12'h403};
        logic [7:0]  mk [3] = '{8'h0B, 8'hBF, 8'h7F};
        foreach (pg[i]) begin
            rdr({4'h1, pg[i]}, 8'h00);
            wr({4'h1, pg[i]}, 8'hFF);
            rdr({4'h1, pg[i]}, mk[i]);
            rdr({4'h7, pg[i]}, 8'h00);
            wr({4'h1, pg[i]}, 8'h00);
        end
        wr(16'h5400, 8'hFF);
        rdr(16'h5400, 8'h00);
        rdr(16'h1402, 8'h00);
    endtask
    task automatic t_size;
        fr(3'h1, 14'h0040, 5'h00, 5'h18, 14'h0000, MF);
        fr(3'h1, 14'h05EE, 5'h00, 5'h18, 14'h0000, MF);
        fr(3'h1, 14'h05EF, 5'h00, 5'h10, 14'h0000, MF);
        fr(3'h1, 14'h003F, 5'h00, 5'h10, 14'h0000, MF);
        fr(3'h1, 14'h0064, 5'h02, 5'h10, 14'h0000, MF);
        wr(16'h1400, 8'h01);
        fr(3'h1, 14'h233A, 5'h00, 5'h18, 14'h0000, MF);
        fr(3'h1, 14'h233B, 5'h00, 5'h10, 14'h0000, MF);
        wr(16'h1401, 8'h01);
        fr(3'h1, 14'h233B, 5'h00, 5'h1C, 14'h0000, MF);
        fr(3'h1, 14'h0040, 5'h01, 5'h10, 14'h0000, MF);
        @(posedge clk_sys);
        filt <= 1'b0;
        fr(3'h1, 14'h0040, 5'h01, 5'h18, 14'h0000, MF);
        fr(3'h5, 14'h0040, 5'h00, 5'h10, 14'h0000, MF | MC);
        fr(3'h7, 14'h0040, 5'h00, 5'h18, 14'h0000, MF);
    endtask
    task automatic t_storm;
        @(posedge clk_sys);
        sexc <= 5'h01;
        fr(3'h1, 14'h0040, 5'h10, 5'h18, 14'h0000, MF);
        wr(16'h1400, 8'h02);
        fr(3'h1, 14'h0040, 5'h10, 5'h10, 14'h0000, MF);
        fr(3'h1, 14'h0040, 5'h00, 5'h18, 14'h0000, MF);
        @(posedge clk_sys);
        sexc <= 5'h00;
    endtask
    task automatic t_charge;
        logic [7:0]  cf [7] = '{8'h00, 8'h02, 8'h01, 8'h03, 8'h23, 8'h21, 8'h40};
        logic [13:0] ch [7] = '{14'h0064, 14'h0070, 14'h006C, 14'h0078, 14'h0001, 14'h0001,
                                14'h0064};
        foreach (cf[i]) begin
            wr(16'h1403, cf[i]);
            fr(3'h1, 14'h0064, 5'h00, {4'h0, ~cf[i][6]}, ch[i], MG);
        end
    endtask
    // Frame kinds ordered unicast, flood, multicast, broadcast: counted when kind >= mode
    task automatic t_mode;
        for (int m = 0; m < 4; m++) begin
            wr(16'h1403, 8'(m << 2));
            for (int t = 0; t < 4; t++) begin
                fr(3'h1, 14'h0064, (t == 0) ? 5'h00 : 5'(5'h02 << t), {3'h0, t >= m, 1'b0},
                   14'h0000, MC);
            end
        end
    endtask
    task automatic t_snap;
        wr(16'h2403, 8'h20);
        fr(3'h2, 14'h0064, 5'h00, 5'h01, 14'h0001, MG);
        wr(16'h1403, 8'h00);
        st.frame_begin(3'h1);
        wr(16'h1403, 8'h20);
        st.frame_end(3'h1, 14'h0064, 5'h00, 3'h2);
        #1;
        chk_dec({5'h01, 14'h0064}, MG);
        fr(3'h1, 14'h0064, 5'h00, 5'h01, 14'h0001, MG);
    endtask
    task automatic t_fc;
        wr(16'h1401, 8'h08);
        wr(16'h1403, 8'h10);
        fc(5'h08, 10'h020);
        fc(5'h03, 10'h020);
        fc(5'h1C, 10'h001);
        fc(5'h11, 10'h000);
        fc(5'h13, 10'h001);
        wr(16'h1403, 8'h00);
        fc(5'h13, 10'h000);
        wr(16'h1401, 8'h00);
        fc(5'h08, 10'h000);
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        t_strap;
        t_regs;
        t_size;
        t_storm;
        t_charge;
        t_mode;
        t_snap;
        t_fc;
        give_verdict;
    end
    // Whole run needs well under 2000 cycles
    initial begin
        #100000;
        fail_count++;
        give_verdict;
    end
endmodule
